/* File: common/fpu_pkg.sv */
// package for the flash patch unit: comparator counts, address map, encodings
// assumes a 32-bit byte-addressed core fetch bus
package fpu_pkg;
  localparam int unsigned FPU_NUM_LIT = 2;
  localparam int unsigned FPU_NUM_INS = 6;
  localparam int unsigned FPU_NUM_CMP = 8;
  localparam int unsigned FPU_SLOT_SHIFT = 2;
  localparam logic [31:0] FPU_FLASH_BASE = 32'h0000_0000;
  localparam logic [31:0] FPU_FLASH_LIMIT = 32'h1fff_ffff;
  localparam logic [31:0] FPU_BKPT_INSN = 32'hbe00_be00;
  localparam logic [31:0] FPU_REMAP_RST = 32'h2000_0000;
  localparam logic [1:0] FPU_ALIGN_MASK = 2'h3;
endpackage : fpu_pkg

/* File: rtl/fpu_flash_patch_unit.sv */
// flash patch unit: compares fetch and literal addresses, remaps to ram or breaks
// assumes the core holds address and kind for one cycle per access request,
// and returns the flash data and remapped data through this block
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - two literal comparators remap loads to ram
// - six instruction comparators remap fetches to ram
// - instruction comparator may return breakpoint instead
// - act only when global and own enable
// - redirect address is remap base plus offset
// - flash result discarded, remapped data delivered
// - protection checks use original flash address
// - unaligned literal loads never remapped
module fpu_flash_patch_unit
  import fpu_pkg::*;
#(
  parameter int unsigned NUM_LIT = FPU_NUM_LIT,
  parameter int unsigned NUM_INS = FPU_NUM_INS
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // configuration
  input wire logic i_glob_en,
  input wire logic [NUM_LIT+NUM_INS-1:0] i_cmp_en,
  input wire logic [NUM_INS-1:0] i_cmp_bkpt,
  input wire logic [NUM_LIT+NUM_INS-1:0][31:0] i_cmp_addr,
  input wire logic [31:0] i_remap_base,
  // core request
  input wire logic i_req,
  input wire logic i_req_lit,
  input wire logic [31:0] i_req_addr,
  // memory side data returns
  input wire logic i_flash_vld,
  input wire logic [31:0] i_flash_data,
  input wire logic i_ram_vld,
  input wire logic [31:0] i_ram_data,
  // outputs to memory and checker
  output logic o_bus_req,
  output logic [31:0] o_bus_addr,
  output logic o_remap_req,
  output logic [31:0] o_remap_addr,
  output logic [31:0] o_prot_addr,
  // outputs to core
  output logic o_rsp_vld,
  output logic [31:0] o_rsp_data,
  output logic o_rsp_bkpt
);
  localparam int unsigned NCMP = NUM_LIT + NUM_INS;
  localparam int unsigned IW = $clog2(NCMP);

  // elaboration check: slot map and enables serve at most eight comparators
  if (NUM_LIT < 1 || NUM_INS < 1 || NCMP > FPU_NUM_CMP) begin : g_bad_cfg
    $error("fpu: comparator counts out of range");
  end

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_FLASH = 3'b010,
    ST_PATCH = 3'b100
  } fpu_state_type;

  // ************************************
  // compare
  // ************************************
  logic [NCMP-1:0] hit;
  logic in_flash;
  logic aligned;

  assign in_flash = (i_req_addr >= FPU_FLASH_BASE) && (i_req_addr <= FPU_FLASH_LIMIT);
  assign aligned = (i_req_addr[1:0] & FPU_ALIGN_MASK) == 2'h0;

  genvar g;
  generate
    for (g = 0; g < NCMP; g++) begin : g_cmp
      // literal comparators come first, instruction ones after
      if (g < NUM_LIT) begin : g_lit
        assign hit[g] = i_glob_en && i_cmp_en[g] && i_req_lit && aligned && in_flash
          && (i_cmp_addr[g][31:2] == i_req_addr[31:2]);
      end else begin : g_ins
        assign hit[g] = i_glob_en && i_cmp_en[g] && !i_req_lit && in_flash
          && (i_cmp_addr[g][31:1] == i_req_addr[31:1]);
      end
    end
  endgenerate

  // lowest index wins when two comparators overlap
  logic [IW-1:0] hit_idx;
  logic any_hit;
  always_comb begin
    hit_idx = '0;
    any_hit = 1'b0;
    for (int i = NCMP - 1; i >= 0; i--) begin
      if (hit[i]) begin
        hit_idx = IW'(i);
        any_hit = 1'b1;
      end
    end
  end

  // literal slots padded with zero so the winner index selects directly
  logic [NCMP-1:0] bkpt_sel;
  logic hit_bkpt;
  assign bkpt_sel = {i_cmp_bkpt, {NUM_LIT{1'b0}}};
  assign hit_bkpt = any_hit && bkpt_sel[hit_idx];

  logic [31:0] remap_nxt;
  assign remap_nxt = i_remap_base + (32'(hit_idx) << FPU_SLOT_SHIFT);

  // ************************************
  // access sequencing
  // ************************************
  fpu_state_type state_r;
  logic flash_seen_r;
  logic ram_seen_r;
  logic [31:0] ram_data_r;
  logic patch_done;
  // either memory may answer first; the early answer is held for the other
  assign patch_done = (ram_seen_r || i_ram_vld) && (flash_seen_r || i_flash_vld);

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_r <= ST_IDLE;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (i_req && any_hit && !hit_bkpt) state_r <= ST_PATCH;
          else if (i_req && !any_hit) state_r <= ST_FLASH;
        end
        ST_FLASH: begin
          if (i_flash_vld) state_r <= ST_IDLE;
        end
        ST_PATCH: begin
          // stay until ram answers and the stray flash answer has drained
          if (patch_done) state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // flash access is issued unless a breakpoint hits; a patched one is simply thrown away
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_bus_req <= 1'b0;
      o_bus_addr <= 32'h0000_0000;
      o_prot_addr <= 32'h0000_0000;
    end else begin
      o_bus_req <= (state_r == ST_IDLE) && i_req && !hit_bkpt;
      if (state_r == ST_IDLE && i_req) begin
        o_bus_addr <= i_req_addr;
        o_prot_addr <= i_req_addr;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_remap_req <= 1'b0;
      o_remap_addr <= FPU_REMAP_RST;
    end else begin
      o_remap_req <= (state_r == ST_IDLE) && i_req && any_hit && !hit_bkpt;
      if (state_r == ST_IDLE && i_req && any_hit) o_remap_addr <= remap_nxt;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      flash_seen_r <= 1'b0;
    end else if (state_r == ST_IDLE) begin
      flash_seen_r <= 1'b0;
    end else if (state_r == ST_PATCH && i_flash_vld) begin
      flash_seen_r <= 1'b1;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ram_seen_r <= 1'b0;
      ram_data_r <= 32'h0000_0000;
    end else if (state_r == ST_IDLE) begin
      ram_seen_r <= 1'b0;
    end else if (state_r == ST_PATCH && i_ram_vld) begin
      ram_seen_r <= 1'b1;
      ram_data_r <= i_ram_data;
    end
  end

  // ************************************
  // response to core
  // ************************************
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_rsp_vld <= 1'b0;
      o_rsp_data <= 32'h0000_0000;
      o_rsp_bkpt <= 1'b0;
    end else begin
      o_rsp_vld <= 1'b0;
      o_rsp_bkpt <= 1'b0;
      if (state_r == ST_IDLE && i_req && hit_bkpt) begin
        o_rsp_vld <= 1'b1;
        o_rsp_data <= FPU_BKPT_INSN;
        o_rsp_bkpt <= 1'b1;
      end else if (state_r == ST_FLASH && i_flash_vld) begin
        o_rsp_vld <= 1'b1;
        o_rsp_data <= i_flash_data;
      end else if (state_r == ST_PATCH && patch_done) begin
        o_rsp_vld <= 1'b1;
        o_rsp_data <= i_ram_vld ? i_ram_data : ram_data_r;
      end
    end
  end

  // ************************************
  // checks
  // ************************************
  chk_unaligned_lit_pass: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (state_r == ST_IDLE && i_req && i_req_lit && i_req_addr[1:0] != 2'h0)
      |=> (!o_remap_req && o_bus_req))
    else $error("unaligned literal was remapped");
  chk_disabled_no_remap: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (state_r == ST_IDLE && i_req && !i_glob_en) |=> (!o_remap_req && !o_rsp_bkpt))
    else $error("remap while unit disabled");
  chk_remap_slot_addr: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (state_r == ST_IDLE && i_req && any_hit && !hit_bkpt)
      |=> (o_remap_addr == $past(i_remap_base) + (32'($past(hit_idx)) << FPU_SLOT_SHIFT)))
    else $error("remap address wrong");
  chk_prot_orig_addr: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (state_r == ST_IDLE && i_req) |=> (o_prot_addr == $past(i_req_addr)))
    else $error("protection address not original");
  chk_flash_still_issued: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    o_remap_req |-> o_bus_req)
    else $error("flash access missing on remap");
  chk_patch_data_used: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (state_r == ST_PATCH && i_ram_vld && (flash_seen_r || i_flash_vld))
      |=> (o_rsp_vld && o_rsp_data == $past(i_ram_data)))
    else $error("patched data not delivered");
  chk_patch_late_flash: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (state_r == ST_PATCH && ram_seen_r && i_flash_vld)
      |=> (o_rsp_vld && o_rsp_data == $past(ram_data_r)))
    else $error("held patch data lost on late flash");
  chk_bkpt_returned: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (state_r == ST_IDLE && i_req && hit_bkpt)
      |=> (o_rsp_bkpt && o_rsp_data == FPU_BKPT_INSN && !o_bus_req))
    else $error("breakpoint not returned");
  chk_lit_only_low: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (state_r == ST_IDLE && i_req && i_req_lit && any_hit) |-> (hit_idx < IW'(NUM_LIT)))
    else $error("literal matched instruction comparator");
  chk_ins_only_high: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (state_r == ST_IDLE && i_req && !i_req_lit && any_hit) |-> (hit_idx >= IW'(NUM_LIT)))
    else $error("fetch matched literal comparator");
  chk_slot_stride: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    o_remap_req |-> (o_remap_addr[1:0] == i_remap_base[1:0]))
    else $error("slot stride not word");
endmodule : fpu_flash_patch_unit
`default_nettype wire

/* File: testbench/fpu_mem_model.sv */
// memory side model: flash and ram answer one access each, short or long wait
// assumes one outstanding access and one-cycle request pulses from the unit
`timescale 1ns/1ps
`default_nettype none
module fpu_mem_model (
  // clock, reset, pacing
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_slow,
  // requests
  input wire logic i_bus_req,
  input wire logic [31:0] i_bus_addr,
  input wire logic i_remap_req,
  input wire logic [31:0] i_remap_addr,
  // answers
  output logic o_flash_vld,
  output logic [31:0] o_flash_data,
  output logic o_ram_vld,
  output logic [31:0] o_ram_data
);
  logic [3:0] f_cnt_r;
  logic [3:0] r_cnt_r;
  logic [31:0] f_addr_r;
  logic [31:0] r_addr_r;
  // slow: ram answers before flash; fast: flash first
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      f_cnt_r <= 4'h0;
      r_cnt_r <= 4'h0;
      o_flash_vld <= 1'b0;
      o_ram_vld <= 1'b0;
      o_flash_data <= 32'h0;
      o_ram_data <= 32'h0;
    end else begin
      o_flash_vld <= (f_cnt_r == 4'h1);
      o_ram_vld <= (r_cnt_r == 4'h1);
      // idle data toggles so a stale word never looks good
      o_flash_data <= (f_cnt_r == 4'h1) ? f_addr_r ^ 32'hf0f0_f0f0 : ~o_flash_data;
      o_ram_data <= (r_cnt_r == 4'h1) ? r_addr_r ^ 32'h0f0f_0f0f : ~o_ram_data;
      f_cnt_r <= i_bus_req ? (i_slow ? 4'h6 : 4'h1) : f_cnt_r - {3'h0, f_cnt_r != 4'h0};
      r_cnt_r <= i_remap_req ? (i_slow ? 4'h2 : 4'h3) : r_cnt_r - {3'h0, r_cnt_r != 4'h0};
      if (i_bus_req) f_addr_r <= i_bus_addr;
      if (i_remap_req) r_addr_r <= i_remap_addr;
    end
  end
endmodule : fpu_mem_model
`default_nettype wire

/* File: testbench/fpu_flash_patch_unit_bench.sv */
// bench for the flash patch unit: gating, remap, literals, breakpoints
// assumes fpu_pkg and the memory model are compiled first
`timescale 1ns/1ps
`default_nettype none
module fpu_flash_patch_unit_bench;
  import fpu_pkg::*;
  logic i_clk = 1'b0, i_sys_rst = 1'b1, i_glob_en = 1'b1, i_slow = 1'b0;
  logic i_req = 1'b0, i_req_lit = 1'b0;
  logic [7:0] i_cmp_en = 8'h0;
  logic [5:0] i_cmp_bkpt = 6'h0;
  logic [7:0][31:0] i_cmp_addr;
  logic [31:0] i_remap_base = 32'h2000_0400, i_req_addr = 32'h0;
  logic [31:0] i_flash_data, i_ram_data, o_bus_addr, o_remap_addr, o_prot_addr, o_rsp_data;
  logic i_flash_vld, i_ram_vld, o_bus_req, o_remap_req, o_rsp_vld, o_rsp_bkpt;
  int n_mismatch = 0;
  int samples_checked = 0;
  always #12.5 i_clk = ~i_clk;
  fpu_flash_patch_unit u_dut (.i_clk, .i_sys_rst, .i_glob_en, .i_cmp_en, .i_cmp_bkpt,
    .i_cmp_addr, .i_remap_base, .i_req, .i_req_lit, .i_req_addr, .i_flash_vld,
    .i_flash_data, .i_ram_vld, .i_ram_data, .o_bus_req, .o_bus_addr, .o_remap_req,
    .o_remap_addr, .o_prot_addr, .o_rsp_vld, .o_rsp_data, .o_rsp_bkpt);
  fpu_mem_model u_mem (.i_clk, .i_sys_rst, .i_slow, .i_bus_req(o_bus_req),
    .i_bus_addr(o_bus_addr), .i_remap_req(o_remap_req), .i_remap_addr(o_remap_addr),
    .o_flash_vld(i_flash_vld), .o_flash_data(i_flash_data), .o_ram_vld(i_ram_vld),
    .o_ram_data(i_ram_data));
  // ********************
  // checks and accesses
  // ********************
  task automatic cmp_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp_word
  // idx below zero: no remap expected
  task automatic access(input logic lit, input logic [31:0] addr, input int idx, input logic bk);
    logic rmp;
    logic bus;
    logic [31:0] ra;
    rmp = 1'b0;
    bus = 1'b0;
    ra = i_remap_base + 32'(idx * 4);
    @(posedge i_clk);
    i_req <= 1'b1;
    i_req_lit <= lit;
    i_req_addr <= addr;
    @(posedge i_clk);
    i_req <= 1'b0;
    for (int n = 0; n < 40; n++) begin
      #1;
      if (o_remap_req === 1'b1) rmp = 1'b1;
      if (o_bus_req === 1'b1) bus = 1'b1;
      if (o_rsp_vld === 1'b1) break;
      @(posedge i_clk);
    end
    cmp_word("rsp_vld", 32'h1, {31'h0, o_rsp_vld});
    cmp_word("rsp_bkpt", {31'h0, bk}, {31'h0, o_rsp_bkpt});
    cmp_word("bus_req", {31'h0, !bk}, {31'h0, bus});
    cmp_word("bus_addr", addr, o_bus_addr);
    cmp_word("remap_req", {31'h0, idx >= 0}, {31'h0, rmp});
    cmp_word("prot_addr", addr, o_prot_addr);
    if (idx >= 0) cmp_word("remap_addr", ra, o_remap_addr);
    cmp_word("rsp_data", bk ? FPU_BKPT_INSN : (idx >= 0 ? ra ^ 32'h0f0f_0f0f
      : addr ^ 32'hf0f0_f0f0), o_rsp_data);
  endtask : access
  task automatic t_gate;
    @(posedge i_clk);
    i_cmp_addr[2] <= 32'h0000_1000;
    i_cmp_en <= 8'h04;
    i_glob_en <= 1'b0;
    access(1'b0, 32'h0000_1000, -1, 1'b0);
    @(posedge i_clk);
    i_glob_en <= 1'b1;
    i_cmp_en <= 8'hfb;
    access(1'b0, 32'h0000_1000, -1, 1'b0);
    @(posedge i_clk);
    i_cmp_en <= 8'h0c;
    i_cmp_addr[3] <= 32'h2000_0100;
    access(1'b0, 32'h0000_1000, 2, 1'b0);
    access(1'b0, 32'h2000_0100, -1, 1'b0);
    // put comparator 3 back into flash space for the sweep
    @(posedge i_clk);
    i_cmp_addr[3] <= 32'h0000_4300;
  endtask : t_gate
  task automatic t_ins;
    for (int k = 2; k < 8; k++) begin
      @(posedge i_clk);
      i_cmp_en <= 8'h01 << k;
      i_slow <= k[0];
      access(1'b0, i_cmp_addr[k], k, 1'b0);
      access(1'b0, i_cmp_addr[k] + 32'h2, -1, 1'b0);
    end
  endtask : t_ins
  task automatic t_lit;
    for (int k = 0; k < 2; k++) begin
      @(posedge i_clk);
      i_cmp_en <= 8'h01 << k;
      access(1'b1, i_cmp_addr[k], k, 1'b0);
      access(1'b1, i_cmp_addr[k] + 32'h1, -1, 1'b0);
    end
  endtask : t_lit
  task automatic t_bkpt;
    @(posedge i_clk);
    i_cmp_en <= 8'hc0;
    i_cmp_bkpt <= 6'h20;
    access(1'b0, i_cmp_addr[7], -1, 1'b1);
    access(1'b0, i_cmp_addr[6], 6, 1'b0);
  endtask : t_bkpt
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : report_and_stop
  initial begin
    for (int k = 0; k < 8; k++) i_cmp_addr[k] = 32'h0000_4000 + 32'(k * 256);
    repeat (16) @(posedge i_clk);
    cmp_word("remap_addr_rst", FPU_REMAP_RST, o_remap_addr);
    i_sys_rst <= 1'b0;
    t_gate();
    t_ins();
    t_lit();
    t_bkpt();
    report_and_stop();
  end
  // 22 accesses of at most 12 cycles each
  initial begin
    repeat (3000) @(posedge i_clk);
    n_mismatch++;
    report_and_stop();
  end
endmodule : fpu_flash_patch_unit_bench
`default_nettype wire
